// *** pkg/pio_pkg.sv ***
// Purpose: shared constants and types for the two-port pulse I/O block
// Assumes: 100 MHz ref_clk, 16-bit configuration objects selected by identifier
// Notes:   object identifiers are the selector values on the register port
package pio_pkg;

  localparam int REG_W = 16;

  // configuration object identifiers
  localparam logic [15:0] OBJ_P1_MODE    = 16'h32f0;
  localparam logic [15:0] OBJ_P1_ACCUM   = 16'h32fa;
  localparam logic [15:0] OBJ_P1_SCALING = 16'h3304;
  localparam logic [15:0] OBJ_P2_MODE    = 16'h330e;
  localparam logic [15:0] OBJ_P2_ACCUM   = 16'h3318;
  localparam logic [15:0] OBJ_P2_SCALING = 16'h3322;
  localparam logic [15:0] OBJ_P1_SOURCE  = 16'h3a98;
  localparam logic [15:0] OBJ_P1_RELAY   = 16'h3aa2;
  localparam logic [15:0] OBJ_PULSE_SCALAR = 16'h2efe;
  localparam logic [15:0] OBJ_P1_COMPANION = 16'hb036;
  localparam logic [15:0] OBJ_P2_COMPANION = 16'hb09a;

  // output source codes
  localparam logic [15:0] SRC_NONE     = 16'h0000;
  localparam logic [15:0] SRC_REAL     = 16'habe1;
  localparam logic [15:0] SRC_REACTIVE = 16'habe8;
  localparam logic [15:0] SRC_APPARENT = 16'habeb;

  // relay polarity codes
  localparam logic [15:0] RELAY_NO = 16'h0000;
  localparam logic [15:0] RELAY_NC = 16'h0001;

  // reset values
  localparam logic [15:0] SCALING_RST = 16'h03e8;
  localparam logic [15:0] SCALAR_RST  = 16'h0001;

  // scaling value is a fraction times this divisor
  localparam logic [16:0] SCALE_DIV = 17'h003e8;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_WIDTH_MS  = 100;
  localparam int PULSE_WIDTH_CYC = PULSE_WIDTH_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PIO_MODE_OFF  = 2'h0,
    PIO_MODE_RISE = 2'h1,
    PIO_MODE_FALL = 2'h2,
    PIO_MODE_BOTH = 2'h3
  } pio_mode_t;

  typedef enum logic [1:0] {
    PIO_OUT_IDLE  = 2'b01,
    PIO_OUT_PULSE = 2'b10
  } pio_out_state_t;

  function automatic logic [6:0] pio_div_scale(input logic [16:0] v);
    return 7'(v / SCALE_DIV);
  endfunction

  function automatic logic [9:0] pio_rem_scale(input logic [16:0] v);
    return 10'(v % SCALE_DIV);
  endfunction

endpackage

// *** logic/pio_edge_counter.sv ***
// Purpose: one port's input synchroniser, edge selector and scaled accumulator
// Assumes: pinRaw is asynchronous; mode, scaling and writes come from ref_clk logic
// Notes:   a software write to the accumulator wins over a same-cycle edge
`timescale 1ns/1ps
module pio_edge_counter (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // pin
  input  wire logic             pinRaw,
  // configuration
  input  wire pio_pkg::pio_mode_t mode,
  input  wire logic [15:0]      scaling,
  // accumulator access
  input  wire logic             accWr,
  input  wire logic [15:0]      accWdata,
  output logic      [15:0]      accum,
  output logic                  pinLevel
);
  import pio_pkg::*;

  logic [1:0]  syncQ;
  logic        levelQ;
  logic [15:0] accumQ;
  logic [9:0]  residueQ;
  logic        riseEdge;
  logic        fallEdge;
  logic        countEvt;
  logic [16:0] sum;
  logic [6:0]  whole;
  logic [9:0]  rem;

  // two-stage synchroniser, edges taken from registered samples
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      syncQ  <= 2'h0;
      levelQ <= 1'b0;
    end
    else
    begin
      syncQ  <= {syncQ[0], pinRaw};
      levelQ <= syncQ[1];
    end
  end

  assign riseEdge = levelQ == 1'b0 && syncQ[1] == 1'b1;
  assign fallEdge = levelQ == 1'b1 && syncQ[1] == 1'b0;

  always_comb
  begin
    unique case (mode)
      PIO_MODE_OFF:  countEvt = 1'b0;
      PIO_MODE_RISE: countEvt = riseEdge;
      PIO_MODE_FALL: countEvt = fallEdge;
      PIO_MODE_BOTH: countEvt = riseEdge | fallEdge;
    endcase
  end

  // each counted edge adds scaling thousandths
  assign sum   = {7'h00, residueQ} + {1'b0, scaling};
  assign whole = pio_div_scale(sum);
  assign rem   = pio_rem_scale(sum);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      accumQ   <= 16'h0000;
      residueQ <= 10'h000;
    end
    else if (accWr)
    begin
      accumQ   <= accWdata;
      residueQ <= 10'h000;
    end
    else if (countEvt)
    begin
      accumQ   <= accumQ + {9'h000, whole};
      residueQ <= rem;
    end
  end

  assign accum    = accumQ;
  assign pinLevel = levelQ;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  off_no_count_a: assert property ((mode == PIO_MODE_OFF && !accWr) |=> $stable(accumQ))
    else $error("accumulator moved while counting is off");
  rise_only_a: assert property (
    (mode == PIO_MODE_RISE && !accWr && syncQ[1] && !levelQ)
      |=> residueQ == pio_rem_scale({7'h00, $past(residueQ)} + {1'b0, $past(scaling)}))
    else $error("rising edge not counted in rising mode");
  rise_skip_fall_a: assert property ((mode == PIO_MODE_RISE && !accWr && fallEdge)
    |=> $stable(accumQ) && $stable(residueQ))
    else $error("falling edge counted in rising mode");
  fall_only_a: assert property ((mode == PIO_MODE_FALL && !accWr && riseEdge)
    |=> $stable(accumQ) && $stable(residueQ))
    else $error("rising edge counted in falling mode");
  both_edges_a: assert property ((mode == PIO_MODE_BOTH && !accWr && (riseEdge || fallEdge))
    |=> accumQ == $past(accumQ) + {9'h000, pio_div_scale({7'h00, $past(residueQ)}
                                                        + {1'b0, $past(scaling)})})
    else $error("edge not counted in both-edge mode");
  scale_whole_a: assert property ((countEvt && !accWr && scaling == SCALING_RST)
    |=> accumQ == $past(accumQ) + 16'h0001)
    else $error("unity scaling did not add one");
  single_count_a: assert property (riseEdge |=> !riseEdge)
    else $error("one rising edge seen twice");

endmodule

// *** logic/pio_port_counter.sv ***
// Purpose: two digital I/O ports, each a pulse counter, with port 1 as energy pulse output
// Assumes: register port addressed by object identifier; energy pulses are ref_clk strobes
// Notes:   output pulse width is in ref_clk cycles; accumulators count pin edges
//
// Overview of operation
// - A port whose input mode is zero counts nothing and its accumulator holds.
// - Mode one counts each rising edge and ignores falling edges.
// - Mode two counts each falling edge and ignores rising edges.
// - Mode three counts both rising and falling edges.
// - Writing a counting mode to a port turns off pulse output on that port.
// - Writing a nonzero port 1 mode clears the port 1 companion register.
// - Writing a nonzero port 2 mode clears the port 2 companion register.
// - With counting off, the general-purpose on/off function drives port 2, and port 1 when its output source is zero.
// - The accumulator adds scaling divided by one thousand per counted edge.
// - A zero port 1 output source gives no energy pulses and a plain switch.
// - The port 1 source code selects real, reactive or apparent energy pulses.
// - Relay type zero idles the output high, relay type one idles it low.
// - The pulse scalar sets how many energy pulses make one output pulse.
`timescale 1ns/1ps
module pio_port_counter #(
  parameter int unsigned PULSE_CYC = pio_pkg::PULSE_WIDTH_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // configuration object access
  input  wire logic [15:0] objSel,
  input  wire logic        objWr,
  input  wire logic [15:0] objWdata,
  output logic      [15:0] objRdata,
  output logic             objHit,
  // energy pulse strobes from metering
  input  wire logic        realPulse,
  input  wire logic        reactivePulse,
  input  wire logic        apparentPulse,
  // general-purpose on/off control
  input  wire logic        gpio1Level,
  input  wire logic        gpio1Drive,
  input  wire logic        gpio2Level,
  input  wire logic        gpio2Drive,
  output logic             port1State,
  output logic             port2State,
  // port pins
  input  wire logic        port1In,
  output logic             port1Out,
  output logic             port1Oe,
  input  wire logic        port2In,
  output logic             port2Out,
  output logic             port2Oe
);
  import pio_pkg::*;

  pio_mode_t      p1Mode_q;
  pio_mode_t      p2Mode_q;
  logic [15:0]    p1Scaling_q;
  logic [15:0]    p2Scaling_q;
  logic [15:0]    p1Source_q;
  logic [15:0]    p1Relay_q;
  logic [15:0]    pulseScalar_q;
  logic [15:0]    p1Companion_q;
  logic [15:0]    p2Companion_q;
  logic [15:0]    p1Accum;
  logic [15:0]    p2Accum;
  logic           p1Level;
  logic           p2Level;
  logic           wrP1Mode;
  logic           wrP2Mode;
  logic           modeLegal;
  logic           srcPulse;
  logic [15:0]    srcCount_q;
  logic           fire;
  logic           pending_q;
  pio_out_state_t outState_q;
  logic [31:0]    widthCnt_q;
  logic           pulseActive;
  logic           relayIdle;
  logic           p1Out_d;
  logic           p1Oe_d;
  logic           p2Out_d;
  logic           p2Oe_d;
  logic [15:0]    objRdata_d;
  logic           objHit_d;

  assign wrP1Mode  = objWr && objSel == OBJ_P1_MODE;
  assign wrP2Mode  = objWr && objSel == OBJ_P2_MODE;
  // mode writes above three are refused
  assign modeLegal = objWdata[15:2] == 14'h0000;

  // input modes and scaling
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p1Mode_q    <= PIO_MODE_OFF;
      p2Mode_q    <= PIO_MODE_OFF;
      p1Scaling_q <= SCALING_RST;
      p2Scaling_q <= SCALING_RST;
    end
    else
    begin
      if (wrP1Mode && modeLegal)
        p1Mode_q <= pio_mode_t'(objWdata[1:0]);
      if (wrP2Mode && modeLegal)
        p2Mode_q <= pio_mode_t'(objWdata[1:0]);
      if (objWr && objSel == OBJ_P1_SCALING)
        p1Scaling_q <= objWdata;
      if (objWr && objSel == OBJ_P2_SCALING)
        p2Scaling_q <= objWdata;
    end
  end

  // companion registers, cleared when counting is set up
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p1Companion_q <= 16'h0000;
      p2Companion_q <= 16'h0000;
    end
    else
    begin
      if (wrP1Mode && modeLegal && objWdata[1:0] != 2'h0)
        p1Companion_q <= 16'h0000;
      else if (objWr && objSel == OBJ_P1_COMPANION)
        p1Companion_q <= objWdata;
      if (wrP2Mode && modeLegal && objWdata[1:0] != 2'h0)
        p2Companion_q <= 16'h0000;
      else if (objWr && objSel == OBJ_P2_COMPANION)
        p2Companion_q <= objWdata;
    end
  end

  // pulse output configuration
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p1Source_q    <= SRC_NONE;
      p1Relay_q     <= RELAY_NO;
      pulseScalar_q <= SCALAR_RST;
    end
    else
    begin
      if (wrP1Mode && modeLegal && objWdata[1:0] != 2'h0)
        p1Source_q <= SRC_NONE;
      else if (objWr && objSel == OBJ_P1_SOURCE)
        p1Source_q <= objWdata;
      if (objWr && objSel == OBJ_P1_RELAY)
        p1Relay_q <= objWdata;
      if (objWr && objSel == OBJ_PULSE_SCALAR)
        pulseScalar_q <= objWdata;
    end
  end

  pio_edge_counter u_port1 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinRaw   (port1In),
    .mode     (p1Mode_q),
    .scaling  (p1Scaling_q),
    .accWr    (objWr && objSel == OBJ_P1_ACCUM),
    .accWdata (objWdata),
    .accum    (p1Accum),
    .pinLevel (p1Level)
  );

  pio_edge_counter u_port2 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinRaw   (port2In),
    .mode     (p2Mode_q),
    .scaling  (p2Scaling_q),
    .accWr    (objWr && objSel == OBJ_P2_ACCUM),
    .accWdata (objWdata),
    .accum    (p2Accum),
    .pinLevel (p2Level)
  );

  // energy source select
  always_comb
  begin
    unique case (p1Source_q)
      SRC_REAL:     srcPulse = realPulse;
      SRC_REACTIVE: srcPulse = reactivePulse;
      SRC_APPARENT: srcPulse = apparentPulse;
      default:      srcPulse = 1'b0;
    endcase
  end

  // one output pulse per scalar source pulses; zero scalar acts as one
  assign fire = srcPulse && (srcCount_q + 16'h0001 >= pulseScalar_q);

  always_ff @(posedge ref_clk)
  begin
    if (rst || p1Source_q == SRC_NONE)
      srcCount_q <= 16'h0000;
    else if (fire)
      srcCount_q <= 16'h0000;
    else if (srcPulse)
      srcCount_q <= srcCount_q + 16'h0001;
  end

  // output pulse shaper; one pulse may wait while another is active
  always_ff @(posedge ref_clk)
  begin
    if (rst || p1Source_q == SRC_NONE)
    begin
      outState_q <= PIO_OUT_IDLE;
      widthCnt_q <= 32'h0000_0000;
      pending_q  <= 1'b0;
    end
    else
    begin
      unique case (outState_q)
        PIO_OUT_IDLE:
        begin
          if (fire || pending_q)
          begin
            outState_q <= PIO_OUT_PULSE;
            widthCnt_q <= 32'h0000_0000;
            pending_q  <= 1'b0;
          end
        end
        PIO_OUT_PULSE:
        begin
          if (fire)
            pending_q <= 1'b1;
          if (widthCnt_q >= 32'(PULSE_CYC) - 32'h0000_0001)
            outState_q <= PIO_OUT_IDLE;
          else
            widthCnt_q <= widthCnt_q + 32'h0000_0001;
        end
        default:
          outState_q <= PIO_OUT_IDLE;
      endcase
    end
  end

  assign pulseActive = outState_q == PIO_OUT_PULSE;
  assign relayIdle   = p1Relay_q[0] == 1'b0;

  // pin drive: counting makes the pin an input, else pulses or on/off control
  always_comb
  begin
    if (p1Mode_q != PIO_MODE_OFF)
    begin
      p1Out_d = 1'b0;
      p1Oe_d  = 1'b0;
    end
    else if (p1Source_q != SRC_NONE)
    begin
      p1Out_d = pulseActive ? !relayIdle : relayIdle;
      p1Oe_d  = 1'b1;
    end
    else
    begin
      p1Out_d = gpio1Level;
      p1Oe_d  = gpio1Drive;
    end
    if (p2Mode_q != PIO_MODE_OFF)
    begin
      p2Out_d = 1'b0;
      p2Oe_d  = 1'b0;
    end
    else
    begin
      p2Out_d = gpio2Level;
      p2Oe_d  = gpio2Drive;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      port1Out   <= 1'b0;
      port1Oe    <= 1'b0;
      port2Out   <= 1'b0;
      port2Oe    <= 1'b0;
      port1State <= 1'b0;
      port2State <= 1'b0;
    end
    else
    begin
      port1Out   <= p1Out_d;
      port1Oe    <= p1Oe_d;
      port2Out   <= p2Out_d;
      port2Oe    <= p2Oe_d;
      port1State <= p1Level;
      port2State <= p2Level;
    end
  end

  // registered read of the selected object
  always_comb
  begin
    objHit_d = 1'b1;
    unique case (objSel)
      OBJ_P1_MODE:      objRdata_d = {14'h0000, p1Mode_q};
      OBJ_P1_ACCUM:     objRdata_d = p1Accum;
      OBJ_P1_SCALING:   objRdata_d = p1Scaling_q;
      OBJ_P2_MODE:      objRdata_d = {14'h0000, p2Mode_q};
      OBJ_P2_ACCUM:     objRdata_d = p2Accum;
      OBJ_P2_SCALING:   objRdata_d = p2Scaling_q;
      OBJ_P1_SOURCE:    objRdata_d = p1Source_q;
      OBJ_P1_RELAY:     objRdata_d = p1Relay_q;
      OBJ_PULSE_SCALAR: objRdata_d = pulseScalar_q;
      OBJ_P1_COMPANION: objRdata_d = p1Companion_q;
      OBJ_P2_COMPANION: objRdata_d = p2Companion_q;
      default:
      begin
        objRdata_d = 16'h0000;
        objHit_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      objRdata <= 16'h0000;
      objHit   <= 1'b0;
    end
    else
    begin
      objRdata <= objRdata_d;
      objHit   <= objHit_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence set_count_s;
    wrP1Mode && modeLegal && objWdata[1:0] != 2'h0;
  endsequence

  pulse_off_a: assert property (set_count_s |=> p1Source_q == SRC_NONE ##1 !port1Oe)
    else $error("pulse output survived a counting mode write");
  comp1_clear_a: assert property (set_count_s |=> p1Companion_q == 16'h0000)
    else $error("port 1 companion not cleared");
  comp2_clear_a: assert property (
    (wrP2Mode && modeLegal && objWdata[1:0] != 2'h0) |=> p2Companion_q == 16'h0000)
    else $error("port 2 companion not cleared");
  gpio_hand_a: assert property ((p2Mode_q == PIO_MODE_OFF)
    |=> port2Oe == $past(gpio2Drive) && port2Out == $past(gpio2Level))
    else $error("port 2 not under on/off control");
  no_pulse_a: assert property ((p1Source_q == SRC_NONE) |=> !pulseActive)
    else $error("pulse generated with no source");
  src_real_a: assert property ((p1Source_q == SRC_REAL && realPulse && !pulseActive
    && pulseScalar_q == 16'h0001 && !objWr) |=> pulseActive)
    else $error("real energy pulse not passed on");
  relay_idle_a: assert property ((p1Mode_q == PIO_MODE_OFF && p1Source_q != SRC_NONE
    && !pulseActive) |=> port1Oe && port1Out == !$past(p1Relay_q[0]))
    else $error("wrong idle output level");
  scalar_hold_a: assert property ((srcPulse && srcCount_q + 16'h0001 < pulseScalar_q
    && outState_q == PIO_OUT_IDLE && !pending_q && !objWr) |=> !pulseActive)
    else $error("output pulse before scalar reached");

endmodule

// *** tb/pio_pin_partner.sv ***
// Purpose: pulse source and relay load on one port pin
// Assumes: device drives the pin only while its output enable is high
// Notes:   toggles are spaced well beyond the synchroniser depth
`timescale 1ns/1ps
module pio_pin_partner (
  // clock
  input  wire logic ref_clk,
  // device side of the pin
  input  wire logic devOut,
  input  wire logic devOe,
  output logic      pinLevel
);
  logic srcLevel = 1'b0;

  // relay load sees the device level while driven, else the source level
  assign pinLevel = devOe ? devOut : srcLevel;

  task automatic edges(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      srcLevel = ~srcLevel;
      repeat (6) @(negedge ref_clk);
    end
  endtask
endmodule

// *** tb/tb_pio_port_counter.sv ***
// Purpose: self-checking bench for the two-port pulse I/O block
// Assumes: object port reads are one cycle behind objSel
// Notes:   output pulse width shortened to four cycles
`timescale 1ns/1ps
module tb_pio_port_counter;
  import pio_pkg::*;
  localparam int unsigned PCYC = 4;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] objSel = 16'h0000;
  logic        objWr = 1'b0;
  logic [15:0] objWdata = 16'h0000;
  logic [15:0] objRdata;
  logic        objHit;
  logic [2:0]  strobe = 3'h0;
  logic        gpio1Level = 1'b0;
  logic        gpio1Drive = 1'b0;
  logic        gpio2Level = 1'b0;
  logic        gpio2Drive = 1'b0;
  logic        port1State, port2State, port1Out, port1Oe, port2Out, port2Oe;
  logic        pin1, pin2;
  logic [15:0] srcTab [3];
  int          nFail = 0;
  int          checksDone = 0;
  int          cycles = 0;
  int          rises;
  int          expCnt;

  pio_port_counter #(.PULSE_CYC(PCYC)) uut (
    .ref_clk(ref_clk), .rst(rst), .objSel(objSel), .objWr(objWr), .objWdata(objWdata),
    .objRdata(objRdata), .objHit(objHit), .realPulse(strobe[0]),
    .reactivePulse(strobe[1]), .apparentPulse(strobe[2]), .gpio1Level(gpio1Level),
    .gpio1Drive(gpio1Drive), .gpio2Level(gpio2Level), .gpio2Drive(gpio2Drive),
    .port1State(port1State), .port2State(port2State), .port1In(pin1),
    .port1Out(port1Out), .port1Oe(port1Oe), .port2In(pin2), .port2Out(port2Out),
    .port2Oe(port2Oe)
  );
  pio_pin_partner p1 (.ref_clk(ref_clk), .devOut(port1Out), .devOe(port1Oe), .pinLevel(pin1));
  pio_pin_partner p2 (.ref_clk(ref_clk), .devOut(port2Out), .devOe(port2Oe), .pinLevel(pin2));

  always #5 ref_clk = ~ref_clk;

  task automatic stop_test();
    if (nFail == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      nFail = nFail + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp)
    begin
      nFail = nFail + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    objSel = a;
    objWr = 1'b1;
    objWdata = d;
    @(negedge ref_clk);
    objWr = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    objSel = a;
    @(negedge ref_clk);
    chk(objRdata, exp);
  endtask

  // one strobe, then output level at pulse start and after pulse end
  task automatic pulse_chk(input logic [2:0] s, input logic idle, input logic fires);
    @(negedge ref_clk);
    strobe = s;
    @(negedge ref_clk);
    strobe = 3'h0;
    repeat (2) @(negedge ref_clk);
    chk({15'h0, port1Out}, {15'h0, fires ? ~idle : idle});
    repeat (PCYC + 1) @(negedge ref_clk);
    chk({15'h0, port1Out}, {15'h0, idle});
  endtask

  initial
  begin
    srcTab = '{SRC_REAL, SRC_REACTIVE, SRC_APPARENT};
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(OBJ_P1_MODE, 16'h0000);
    rd_chk(OBJ_P1_SCALING, SCALING_RST);
    rd_chk(OBJ_P2_SCALING, SCALING_RST);
    rd_chk(OBJ_P1_SOURCE, SRC_NONE);
    rd_chk(OBJ_P1_RELAY, RELAY_NO);
    rd_chk(OBJ_PULSE_SCALAR, SCALAR_RST);
    chk({15'h0, objHit}, 16'h0001);
    rd_chk(16'h0001, 16'h0000);
    chk({15'h0, objHit}, 16'h0000);
    // counting off: edges leave the accumulator alone
    p1.edges(4);
    rd_chk(OBJ_P1_ACCUM, 16'h0000);
    chk({15'h0, port1State}, {15'h0, pin1});
    // on/off control while counting is off
    @(negedge ref_clk);
    gpio1Level = 1'b1;
    gpio1Drive = 1'b1;
    gpio2Level = 1'b1;
    gpio2Drive = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({14'h0, port1Oe, port1Out}, 16'h0003);
    chk({14'h0, port2Oe, port2Out}, 16'h0003);
    // driven level comes back through the pin synchronisers
    repeat (4) @(negedge ref_clk);
    chk({14'h0, port1State, port2State}, 16'h0003);
    gpio1Drive = 1'b0;
    gpio1Level = 1'b0;
    gpio2Drive = 1'b0;
    gpio2Level = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({14'h0, port2Oe, port2State}, 16'h0000);
    // each counting mode on port 2, three toggles from the current level
    for (int m = 1; m <= 3; m++)
    begin
      rises = p2.srcLevel ? 1 : 2;
      expCnt = (m == 1) ? rises : (m == 2) ? 3 - rises : 3;
      wr(OBJ_P2_MODE, 16'(m));
      wr(OBJ_P2_ACCUM, 16'h0000);
      p2.edges(3);
      rd_chk(OBJ_P2_ACCUM, 16'(expCnt));
      rd_chk(OBJ_P2_MODE, 16'(m));
      chk({15'h0, port2State}, {15'h0, p2.srcLevel});
    end
    // mode values above three are refused
    wr(OBJ_P2_MODE, 16'h0005);
    rd_chk(OBJ_P2_MODE, 16'h0003);
    // half scale: three rises give one, a fourth gives two
    wr(OBJ_P1_MODE, 16'h0001);
    wr(OBJ_P1_SCALING, 16'h01f4);
    wr(OBJ_P1_ACCUM, 16'h0000);
    p1.edges(6);
    rd_chk(OBJ_P1_ACCUM, 16'h0001);
    p1.edges(2);
    rd_chk(OBJ_P1_ACCUM, 16'h0002);
    // companions cleared by a nonzero mode write
    wr(OBJ_P1_COMPANION, 16'h1234);
    wr(OBJ_P2_COMPANION, 16'h5678);
    rd_chk(OBJ_P1_COMPANION, 16'h1234);
    wr(OBJ_P1_MODE, 16'h0002);
    rd_chk(OBJ_P1_COMPANION, 16'h0000);
    rd_chk(OBJ_P2_COMPANION, 16'h5678);
    wr(OBJ_P2_MODE, 16'h0001);
    rd_chk(OBJ_P2_COMPANION, 16'h0000);
    // energy pulse output, each source ignores the other strobes
    wr(OBJ_P1_MODE, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      wr(OBJ_P1_SOURCE, srcTab[i]);
      repeat (2) @(negedge ref_clk);
      chk({14'h0, port1Oe, port1Out}, 16'h0003);
      pulse_chk(3'h7 ^ (3'h1 << i), 1'b1, 1'b0);
      pulse_chk(3'h1 << i, 1'b1, 1'b1);
    end
    wr(OBJ_P1_RELAY, RELAY_NC);
    repeat (2) @(negedge ref_clk);
    chk({15'h0, port1Out}, 16'h0000);
    pulse_chk(3'h4, 1'b0, 1'b1);
    wr(OBJ_PULSE_SCALAR, 16'h0002);
    pulse_chk(3'h4, 1'b0, 1'b0);
    pulse_chk(3'h4, 1'b0, 1'b1);
    wr(OBJ_P1_SOURCE, SRC_NONE);
    pulse_chk(3'h7, 1'b0, 1'b0);
    chk({15'h0, port1Oe}, 16'h0000);
    // a counting mode switches pulse output off
    wr(OBJ_P1_SOURCE, SRC_REAL);
    wr(OBJ_P1_MODE, 16'h0003);
    rd_chk(OBJ_P1_SOURCE, SRC_NONE);
    chk({15'h0, port1Oe}, 16'h0000);
    stop_test();
  end
endmodule
